// ==== logic/sfpi_params.svh ====
`ifndef SFPI_PARAMS_SVH
`define SFPI_PARAMS_SVH

// Bits that make up one serial byte.
`define SFPI_BYTE_BITS   4'h8
// Configuration bit 4 level that switches the restore and pause functions off.
`define SFPI_CFG_DIS_VAL 1'b0
// Number of 64KB sectors in the array.
`define SFPI_SECTORS     10'h200
// Area code from which the whole array is covered.
`define SFPI_FULL_AREA   4'ha
// Output enable patterns, low on each lane that the device drives.
`define SFPI_OE_FLOAT    4'hf
`define SFPI_OE_X1       4'hd
`define SFPI_OE_X2       4'hc
`define SFPI_OE_X4       4'h0
// Layout of the synchronised pin vector.
`define SFPI_SYNC_W      8
`define SFPI_IX_SCLK     0
`define SFPI_IX_CS       1
`define SFPI_IX_DQ       2
`define SFPI_IX_RST      6
`define SFPI_IX_WP       7
`define SFPI_SYNC_RST    8'hfe

`endif

// ==== logic/sfpi_pkg.sv ====
`default_nettype none
package sfpi_pkg;

    // Protocol that the whole device runs in.
    typedef enum logic [1:0] {
        PR_EXTENDED = 2'h0,
        PR_DUAL     = 2'h1,
        PR_QUAD     = 2'h2
    } sfpi_proto_e;

    // Lane width of one command in the extended protocol.
    typedef enum logic [1:0] {
        LN_X1 = 2'h0,
        LN_X2 = 2'h1,
        LN_X4 = 2'h2
    } sfpi_lane_e;

    // Role of the fourth data line on this variant.
    typedef enum logic [1:0] {
        DQ3_DATA    = 2'h0,
        DQ3_RESTORE = 2'h1,
        DQ3_PAUSE   = 2'h2
    } sfpi_dq3_e;

    // Serial engine states.
    typedef enum logic [1:0] {
        ST_STBY = 2'h0,
        ST_CMD  = 2'h1,
        ST_BODY = 2'h2
    } sfpi_state_e;

    // Whole state of the pin engine.
    typedef struct packed {
        sfpi_state_e st;
        logic        armed;
        logic        cs_q;
        logic        sclk_q;
        logic [7:0]  shift;
        logic [3:0]  bitcnt;
        logic [7:0]  rx_byte;
        logic        rx_valid;
        logic        rx_cmd;
        logic [7:0]  tx_shift;
        logic [3:0]  tx_cnt;
        logic        tx_take;
        logic [3:0]  dq_out;
        logic [3:0]  dq_oe_n;
        logic        standby;
        logic        active;
        logic        paused;
        logic        in_reset;
    } sfpi_eng_s;

    // State of the protection check.
    typedef struct packed {
        logic grant;
        logic deny;
    } sfpi_prot_s;

endpackage : sfpi_pkg
`default_nettype wire

// ==== logic/sfpi_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module sfpi_sync #(
    parameter int             W       = 8,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous inputs and their synchronised copy.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfpi_sync_s;

    sfpi_sync_s s_r;
    sfpi_sync_s s_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    // Both stages take a constant under reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule : sfpi_sync
`default_nettype wire

// ==== logic/sfpi_prot.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_params.svh"
module sfpi_prot (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Protection setup.
    input  wire logic       wp_n,
    input  wire logic       prot_en,
    input  wire logic       bottom,
    input  wire logic [3:0] protect_area_field,
    // Operation check.
    input  wire logic       op_req,
    input  wire logic [8:0] op_sector,
    output logic            op_grant,
    output logic            op_deny
);
    import sfpi_pkg::*;

    sfpi_prot_s s_r;
    sfpi_prot_s s_nxt;

    // Tells whether a sector lies in the area that the field selects.
    function automatic logic in_area(input logic bot, input logic [3:0] a, input logic [8:0] sec);
        logic [9:0] cnt;
        cnt = '0;
        if (a >= `SFPI_FULL_AREA) begin
            cnt = `SFPI_SECTORS;
        end else if (a != 4'h0) begin
            cnt = 10'(10'h1 << (a - 4'h1));
        end
        if (bot) begin
            in_area = {1'b0, sec} < cnt;
        end else begin
            in_area = {1'b0, sec} >= 10'(`SFPI_SECTORS - cnt);
        end
    endfunction : in_area

    always_comb begin
        s_nxt.grant = 1'b0;
        s_nxt.deny  = 1'b0;
        if (op_req) begin
            s_nxt.deny  = !wp_n && prot_en && in_area(bottom, protect_area_field, op_sector);
            s_nxt.grant = !s_nxt.deny;
        end
    end

    // One-cycle answers per request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '{grant: 1'b0, deny: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign op_grant = s_r.grant;
    assign op_deny  = s_r.deny;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_wp_refuse: assert property (op_req && !wp_n && prot_en && in_area(bottom, protect_area_field, op_sector)
        |=> op_deny && !op_grant) else $error("protected sector was not refused");
    c_deny: cover property (op_deny);
endmodule : sfpi_prot
`default_nettype wire

// ==== logic/sfpi_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_params.svh"
module sfpi_core #(
    parameter logic                DEDICATED_RESTORE = 1'b1,
    parameter sfpi_pkg::sfpi_dq3_e DQ3_ROLE          = sfpi_pkg::DQ3_PAUSE
) (
    // Core clock and synchronous reset.
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST_N,
    // Serial pins from the host.
    input  wire logic                 CS_N,
    input  wire logic                 SCLK,
    input  wire logic [3:0]           DQ_IN,
    output logic      [3:0]           DQ_OUT,
    output logic      [3:0]           DQ_OE_N,
    input  wire logic                 RESTORE_N,
    input  wire logic                 WP_N,
    // Configuration.
    input  wire sfpi_pkg::sfpi_proto_e PROTOCOL,
    input  wire sfpi_pkg::sfpi_lane_e  CMD_LANES,
    input  wire logic                 DTR_EN,
    input  wire logic                 NVCFG_BIT4,
    input  wire logic                 EVCFG_BIT4,
    input  wire logic                 SR_PROTECT_EN,
    input  wire logic                 PROT_BOTTOM,
    input  wire logic [3:0]           PROTECT_AREA_FIELD,
    input  wire logic                 INTERNAL_BUSY,
    // Received bytes.
    output logic      [7:0]           RX_BYTE,
    output logic                      RX_VALID,
    output logic                      RX_IS_CMD,
    // Bytes to send.
    input  wire logic                 TX_EN,
    input  wire logic [7:0]           TX_DATA,
    output logic                      TX_TAKE,
    // Program or erase check.
    input  wire logic                 OP_REQ,
    input  wire logic [8:0]           OP_SECTOR,
    output logic                      OP_GRANT,
    output logic                      OP_DENY,
    // Device status.
    output logic                      STANDBY,
    output logic                      ACTIVE,
    output logic                      PAUSED,
    output logic                      IN_RESET
);
    import sfpi_pkg::*;

    // Engine state after reset or restore.
    localparam sfpi_eng_s ENG_RST = '{
        st: ST_STBY, armed: 1'b0, cs_q: 1'b1, sclk_q: 1'b0, shift: 8'h00, bitcnt: 4'h0,
        rx_byte: 8'h00, rx_valid: 1'b0, rx_cmd: 1'b0, tx_shift: 8'h00, tx_cnt: 4'h0,
        tx_take: 1'b0, dq_out: 4'h0, dq_oe_n: `SFPI_OE_FLOAT, standby: 1'b1, active: 1'b0,
        paused: 1'b0, in_reset: 1'b0};

    sfpi_eng_s                s_r;
    sfpi_eng_s                s_nxt;
    logic [`SFPI_SYNC_W-1:0]  pins_s;
    logic                     sclk_s;
    logic                     cs_n_s;
    logic [3:0]               dq_s;
    logic                     rst_pin_s;
    logic                     wp_n_s;
    logic                     cfg_dis;
    logic                     in_cmd;
    logic [2:0]               lanes;
    logic                     rise;
    logic                     fall;
    logic                     hold_act;
    logic                     restore_req;

    // Number of lanes used by the current phase.
    function automatic logic [2:0] lanes_of(input sfpi_proto_e p, input sfpi_lane_e w, input logic cmd);
        lanes_of = 3'h1;
        if (p == PR_QUAD) begin
            lanes_of = 3'h4;
        end else if (p == PR_DUAL) begin
            lanes_of = 3'h2;
        end else if (!cmd && w == LN_X4) begin
            lanes_of = 3'h4;
        end else if (!cmd && w == LN_X2) begin
            lanes_of = 3'h2;
        end
    endfunction : lanes_of

    // Shifts the sampled lanes in at the low end.
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] dq, input logic [2:0] n);
        shift_in = {sh[6:0], dq[0]};
        if (n == 3'h2) begin
            shift_in = {sh[5:0], dq[1:0]};
        end else if (n == 3'h4) begin
            shift_in = {sh[3:0], dq[3:0]};
        end
    endfunction : shift_in

    // Output enable pattern for a lane count.
    function automatic logic [3:0] oe_of(input logic [2:0] n);
        oe_of = `SFPI_OE_X1;
        if (n == 3'h2) begin
            oe_of = `SFPI_OE_X2;
        end else if (n == 3'h4) begin
            oe_of = `SFPI_OE_X4;
        end
    endfunction : oe_of

    // Places the top bits of a byte on the driven lanes.
    function automatic logic [3:0] out_of(input logic [7:0] b, input logic [2:0] n);
        out_of = {2'h0, b[7], 1'b0};
        if (n == 3'h2) begin
            out_of = {2'h0, b[7:6]};
        end else if (n == 3'h4) begin
            out_of = b[7:4];
        end
    endfunction : out_of

    // All pins come from the host's domain and pass two flip-flops.
    sfpi_sync #(
        .W       (`SFPI_SYNC_W),
        .RST_VAL (`SFPI_SYNC_RST)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     ({WP_N, RESTORE_N, DQ_IN, CS_N, SCLK}),
        .q     (pins_s)
    );

    assign sclk_s    = pins_s[`SFPI_IX_SCLK];
    assign cs_n_s    = pins_s[`SFPI_IX_CS];
    assign dq_s      = pins_s[`SFPI_IX_DQ +: 4];
    assign rst_pin_s = pins_s[`SFPI_IX_RST];
    assign wp_n_s    = pins_s[`SFPI_IX_WP];

    // Write protect check on program and erase requests.
    sfpi_prot u_prot (
        .clk                (CORE_CLK),
        .rst_n              (RST_N),
        .wp_n               (wp_n_s),
        .prot_en            (SR_PROTECT_EN),
        .bottom             (PROT_BOTTOM),
        .protect_area_field (PROTECT_AREA_FIELD),
        .op_req             (OP_REQ),
        .op_sector          (OP_SECTOR),
        .op_grant           (OP_GRANT),
        .op_deny            (OP_DENY)
    );

    // Clock edges found from the sampled serial clock.
    assign rise   = sclk_s && !s_r.sclk_q;
    assign fall   = !sclk_s && s_r.sclk_q;
    assign in_cmd = s_r.st == ST_CMD;
    assign lanes  = lanes_of(PROTOCOL, CMD_LANES, in_cmd);

    assign cfg_dis = (NVCFG_BIT4 == `SFPI_CFG_DIS_VAL) || (EVCFG_BIT4 == `SFPI_CFG_DIS_VAL);

    assign hold_act = (DQ3_ROLE == DQ3_PAUSE) && !cs_n_s && !dq_s[3] && !cfg_dis
                      && PROTOCOL != PR_QUAD && !DTR_EN && lanes != 3'h4;

    assign restore_req = (DEDICATED_RESTORE && !rst_pin_s && !cfg_dis)
                         || ((DQ3_ROLE == DQ3_RESTORE) && !cs_n_s && !dq_s[3] && !cfg_dis
                             && PROTOCOL != PR_QUAD && lanes != 3'h4);

    // Next state of the serial engine.
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rx_valid = 1'b0;
        s_nxt.tx_take  = 1'b0;
        s_nxt.sclk_q   = sclk_s;
        s_nxt.cs_q     = cs_n_s;
        // standby while deselected, unless an internal cycle runs.
        s_nxt.standby  = cs_n_s && !INTERNAL_BUSY;
        if (restore_req) begin
            s_nxt          = ENG_RST;
            s_nxt.sclk_q   = sclk_s;
            s_nxt.cs_q     = cs_n_s;
            s_nxt.standby  = cs_n_s && !INTERNAL_BUSY;
            s_nxt.in_reset = 1'b1;
        end else if (cs_n_s) begin
            s_nxt.st       = ST_STBY;
            s_nxt.dq_oe_n  = `SFPI_OE_FLOAT;
            s_nxt.paused   = 1'b0;
            s_nxt.bitcnt   = 4'h0;
            s_nxt.tx_cnt   = 4'h0;
            s_nxt.in_reset = 1'b0;
        end else if (s_r.cs_q) begin
            s_nxt.st       = ST_CMD;
            s_nxt.armed    = 1'b1;
            s_nxt.bitcnt   = 4'h0;
            s_nxt.tx_cnt   = 4'h0;
            s_nxt.in_reset = 1'b0;
        end else if (hold_act) begin
            s_nxt.paused  = 1'b1;
            s_nxt.dq_oe_n = `SFPI_OE_FLOAT;
        end else if (s_r.armed && s_r.st != ST_STBY) begin
            s_nxt.paused = 1'b0;
            // input sampling edges.
            // Command bits are taken even in an output phase; a data byte starts on a rising edge.
            if ((!TX_EN || in_cmd) && (rise || (fall && DTR_EN && !in_cmd && s_r.bitcnt != 4'h0))) begin
                s_nxt.shift  = shift_in(s_r.shift, dq_s, lanes);
                s_nxt.bitcnt = s_r.bitcnt + {1'b0, lanes};
                if (s_r.bitcnt + {1'b0, lanes} >= `SFPI_BYTE_BITS) begin
                    s_nxt.bitcnt   = 4'h0;
                    s_nxt.rx_byte  = shift_in(s_r.shift, dq_s, lanes);
                    s_nxt.rx_valid = 1'b1;
                    s_nxt.rx_cmd   = in_cmd;
                    s_nxt.st       = ST_BODY;
                end
            end
            s_nxt.dq_oe_n = (TX_EN && !in_cmd) ? oe_of(lanes) : `SFPI_OE_FLOAT;
            if (TX_EN && !in_cmd && (fall || (rise && DTR_EN))) begin
                s_nxt.dq_out   = out_of((s_r.tx_cnt == 4'h0) ? TX_DATA : s_r.tx_shift, lanes);
                s_nxt.tx_shift = 8'(((s_r.tx_cnt == 4'h0) ? TX_DATA : s_r.tx_shift) << lanes);
                s_nxt.tx_cnt   = s_r.tx_cnt + {1'b0, lanes};
                if (s_r.tx_cnt + {1'b0, lanes} >= `SFPI_BYTE_BITS) begin
                    s_nxt.tx_cnt  = 4'h0;
                    s_nxt.tx_take = 1'b1;
                end
            end
        end
        s_nxt.active = s_nxt.st != ST_STBY;
    end

    // State register.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s_r <= ENG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign DQ_OUT    = s_r.dq_out;
    assign DQ_OE_N   = s_r.dq_oe_n;
    assign RX_BYTE   = s_r.rx_byte;
    assign RX_VALID  = s_r.rx_valid;
    assign RX_IS_CMD = s_r.rx_cmd;
    assign TX_TAKE   = s_r.tx_take;
    assign STANDBY   = s_r.standby;
    assign ACTIVE    = s_r.active;
    assign PAUSED    = s_r.paused;
    assign IN_RESET  = s_r.in_reset;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_standby_float: assert property (cs_n_s |=> DQ_OE_N == `SFPI_OE_FLOAT && !ACTIVE
        ) else $error("deselected device did not float");
    a_dedicated_restore: assert property (DEDICATED_RESTORE && !rst_pin_s && !cfg_dis && cs_n_s
        |=> IN_RESET) else $error("dedicated restore ignored while deselected");
    a_select_active: assert property (s_r.cs_q && !cs_n_s && !restore_req
        |=> ACTIVE && s_r.st == ST_CMD) else $error("select did not activate");
    a_cmd_rise_only: assert property (in_cmd && fall && !cs_n_s && !s_r.cs_q && !restore_req
        |=> $stable(s_r.bitcnt)) else $error("command bit taken on falling edge");
    a_str_drive_fall: assert property (!DTR_EN && rise && !restore_req && !cs_n_s
        |=> $stable(DQ_OUT)) else $error("single rate output moved on rising edge");
    a_dtr_sample_fall: assert property (DTR_EN && fall && s_r.st == ST_BODY && !TX_EN && !cs_n_s && s_r.bitcnt != 4'h0
        && !s_r.cs_q && !restore_req |=> RX_VALID || s_r.bitcnt != $past(s_r.bitcnt)
        ) else $error("double rate falling edge not sampled");
    a_restore_float: assert property (restore_req |=> IN_RESET && DQ_OE_N == `SFPI_OE_FLOAT
        ) else $error("restore did not float outputs");
    a_cfg_disable: assert property (cfg_dis |-> !hold_act && !restore_req
        ) else $error("disabled pause or restore acted");
    a_quad_no_shared: assert property (PROTOCOL == PR_QUAD |-> !hold_act && (DEDICATED_RESTORE || !restore_req)
        ) else $error("shared line acted in quad protocol");
    a_hold_freeze: assert property ((hold_act && !s_r.cs_q && !restore_req) ##1 hold_act
        |-> $stable(s_r.bitcnt) && PAUSED && DQ_OE_N == `SFPI_OE_FLOAT
        ) else $error("pause did not freeze the transfer");
    a_dtr_no_pause: assert property (DTR_EN |-> !hold_act
        ) else $error("pause acted in double rate");
    a_single_lane: assert property ((!cs_n_s && lanes == 3'h1 && !restore_req && !hold_act) [*2]
        |-> DQ_OE_N[0] && DQ_OE_N[3:2] == 2'h3) else $error("single mode drove a wrong lane");

    c_cmd_byte: cover property (RX_VALID && RX_IS_CMD);
    c_pause: cover property (PAUSED ##1 !PAUSED && ACTIVE);
    c_restore: cover property (IN_RESET);
    c_tx_byte: cover property (TX_TAKE);
endmodule : sfpi_core
`default_nettype wire

// ==== sim/sfpi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sfpi_host_model (
    // Pacing clock.
    input  wire logic       clk,
    // Pins toward the device.
    output var  logic       cs_n,
    output var  logic       sclk,
    output var  logic [3:0] dq_in,
    input  wire logic [3:0] dq_out
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        dq_in = 4'hf;
    end

    // Waits core clocks, then steps just past the edge.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // Moves one byte MSB first and gathers what the device drives before each rising edge, or before every edge in double rate.
    task automatic xfer(input int lanes, input bit dtr, input logic [7:0] din, output logic [7:0] dout);
        logic [7:0] sh;
        sh = din;
        dout = 8'h00;
        for (int e = 0; e < 16 / lanes / (dtr ? 2 : 1); e++) begin
            wait_cyc(2);
            if (e % 2 == 0 || dtr) begin
                dq_in = (lanes == 4) ? sh[7:4] : (lanes == 2) ? {2'h3, sh[7:6]} : {3'h7, sh[7]};
                sh = sh << lanes;
            end
            wait_cyc(2);
            if (e % 2 == 0 || dtr) begin
                dout = (lanes == 4) ? {dout[3:0], dq_out} : (lanes == 2) ? {dout[5:0], dq_out[1:0]}
                                                                            : {dout[6:0], dq_out[1]};
            end
            sclk = ~sclk;
        end
        wait_cyc(2);
        dq_in = 4'hf;
    endtask : xfer
endmodule : sfpi_host_model
`default_nettype wire

// ==== sim/tb_serial_flash_pin_interface.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_params.svh"
module tb_serial_flash_pin_interface;
    import sfpi_pkg::*;
    logic        CORE_CLK = 1'b0;
    logic        RST_N, RESTORE_N, WP_N, DTR_EN, NVCFG_BIT4, EVCFG_BIT4, SR_PROTECT_EN, PROT_BOTTOM;
    logic        INTERNAL_BUSY, TX_EN, OP_REQ;
    logic [3:0]  PROTECT_AREA_FIELD;
    logic [7:0]  TX_DATA;
    logic [8:0]  OP_SECTOR;
    sfpi_proto_e PROTOCOL;
    sfpi_lane_e  CMD_LANES;
    wire logic   CS_N, SCLK;
    wire logic [3:0] DQ_IN;
    logic [3:0]  DQ_OUT, DQ_OE_N;
    logic [7:0]  RX_BYTE;
    logic        RX_VALID, RX_IS_CMD, TX_TAKE, OP_GRANT, OP_DENY, STANDBY, ACTIVE, PAUSED, IN_RESET;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          takes = 0;
    logic [8:0]  rxq[$];

    sfpi_core #(.DEDICATED_RESTORE(1'b1), .DQ3_ROLE(DQ3_PAUSE)) dut_u (
        .CORE_CLK           (CORE_CLK),
        .RST_N              (RST_N),
        .CS_N               (CS_N),
        .SCLK               (SCLK),
        .DQ_IN              (DQ_IN),
        .DQ_OUT             (DQ_OUT),
        .DQ_OE_N            (DQ_OE_N),
        .RESTORE_N          (RESTORE_N),
        .WP_N               (WP_N),
        .PROTOCOL           (PROTOCOL),
        .CMD_LANES          (CMD_LANES),
        .DTR_EN             (DTR_EN),
        .NVCFG_BIT4         (NVCFG_BIT4),
        .EVCFG_BIT4         (EVCFG_BIT4),
        .SR_PROTECT_EN      (SR_PROTECT_EN),
        .PROT_BOTTOM        (PROT_BOTTOM),
        .PROTECT_AREA_FIELD (PROTECT_AREA_FIELD),
        .INTERNAL_BUSY      (INTERNAL_BUSY),
        .RX_BYTE            (RX_BYTE),
        .RX_VALID           (RX_VALID),
        .RX_IS_CMD          (RX_IS_CMD),
        .TX_EN              (TX_EN),
        .TX_DATA            (TX_DATA),
        .TX_TAKE            (TX_TAKE),
        .OP_REQ             (OP_REQ),
        .OP_SECTOR          (OP_SECTOR),
        .OP_GRANT           (OP_GRANT),
        .OP_DENY            (OP_DENY),
        .STANDBY            (STANDBY),
        .ACTIVE             (ACTIVE),
        .PAUSED             (PAUSED),
        .IN_RESET           (IN_RESET)
    );
    sfpi_host_model host_u (.clk(CORE_CLK), .cs_n(CS_N), .sclk(SCLK), .dq_in(DQ_IN), .dq_out(DQ_OUT));

    // Core clock at 20 MHz.
    always #25 CORE_CLK = ~CORE_CLK;

    // Collects every received byte with its command flag.
    always @(posedge CORE_CLK) begin
        if (RX_VALID === 1'b1) begin
            rxq.push_back({RX_IS_CMD, RX_BYTE});
        end
        if (TX_TAKE === 1'b1) begin
            takes++;
        end
    end

    // Cuts a hung run short.
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("compared %0d, mismatched %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Compares one value and counts it.
    task automatic cmp(input logic [8:0] got, input logic [8:0] want);
        samples_checked++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : cmp

    // Compares the oldest received byte.
    task automatic chk_rx(input logic [8:0] want);
        logic [8:0] got;
        got = 'x;
        if (rxq.size() != 0) begin
            got = rxq.pop_front();
        end
        cmp(got, want);
    endtask : chk_rx

    // Works out whether a program or erase must be refused.
    function automatic logic exp_deny(input logic wp_n, input logic en, input logic bot, input logic [3:0] a,
                                      input logic [8:0] s);
        int span;
        span = (a == 4'h0) ? 0 : (a >= 4'ha) ? 512 : (1 << (a - 4'h1));
        return !wp_n && en && (bot ? (int'(s) < span) : (int'(s) >= 512 - span));
    endfunction : exp_deny

    // One selected frame: a command byte, then one body byte in or out.
    task automatic frame(input int lanes, input bit dtr, input bit tx);
        logic [7:0] c, b, r, got;
        c = 8'($urandom);
        b = 8'($urandom);
        r = 8'($urandom);
        rxq.delete();
        takes = 0;
        CMD_LANES = (lanes == 1) ? LN_X1 : (lanes == 2) ? LN_X2 : LN_X4;
        DTR_EN = dtr;
        TX_EN = tx;
        TX_DATA = r;
        host_u.cs_n = 1'b0;
        host_u.wait_cyc(5);
        cmp(ACTIVE, 1'b1);
        cmp(STANDBY, 1'b0);
        host_u.xfer((PROTOCOL == PR_QUAD) ? 4 : (PROTOCOL == PR_DUAL) ? 2 : 1, 1'b0, c, got);
        host_u.xfer(lanes, dtr, b, got);
        host_u.wait_cyc(4);
        chk_rx({1'b1, c});
        if (tx) begin
            cmp(got, r);
            cmp(9'(takes), 9'h001);
            cmp(DQ_OE_N, (lanes == 1) ? `SFPI_OE_X1 : (lanes == 2) ? `SFPI_OE_X2 : `SFPI_OE_X4);
        end else begin
            chk_rx({1'b0, b});
        end
        host_u.cs_n = 1'b1;
        host_u.wait_cyc(5);
        cmp(DQ_OE_N, `SFPI_OE_FLOAT);
        cmp(STANDBY, 1'b1);
        TX_EN = 1'b0;
        $display("frame lanes %0d dtr %0d tx %0d done", lanes, dtr, tx);
    endtask : frame

    // Pause on the fourth line: enabled, both disable bits, double rate, quad protocol.
    task automatic pause_case(input int m);
        logic [7:0] c, b, got;
        c = 8'($urandom);
        b = 8'($urandom);
        rxq.delete();
        EVCFG_BIT4 = (m != 1);
        NVCFG_BIT4 = (m != 2);
        DTR_EN = (m == 3);
        PROTOCOL = (m == 4) ? PR_QUAD : PR_EXTENDED;
        CMD_LANES = LN_X1;
        host_u.cs_n = 1'b0;
        host_u.wait_cyc(5);
        if (m == 0) begin
            host_u.xfer(1, 1'b0, c, got);
        end
        host_u.dq_in = 4'h6;
        host_u.wait_cyc(6);
        cmp(PAUSED, m == 0);
        if (m == 0) begin
            cmp(DQ_OE_N, `SFPI_OE_FLOAT);
            repeat (4) begin
                host_u.sclk = ~host_u.sclk;
                host_u.wait_cyc(4);
            end
            host_u.dq_in = 4'hf;
            host_u.wait_cyc(6);
            host_u.xfer(1, 1'b0, b, got);
            host_u.wait_cyc(4);
            chk_rx({1'b1, c});
            chk_rx({1'b0, b});
        end
        host_u.dq_in = 4'hf;
        host_u.cs_n = 1'b1;
        EVCFG_BIT4 = 1'b1;
        NVCFG_BIT4 = 1'b1;
        DTR_EN = 1'b0;
        PROTOCOL = PR_EXTENDED;
        host_u.wait_cyc(5);
        $display("pause case %0d done", m);
    endtask : pause_case

    // Stimulus and checks in order.
    initial begin
        RST_N = 1'b0;
        RESTORE_N = 1'b1;
        WP_N = 1'b1;
        DTR_EN = 1'b0;
        NVCFG_BIT4 = 1'b1;
        EVCFG_BIT4 = 1'b1;
        SR_PROTECT_EN = 1'b0;
        PROT_BOTTOM = 1'b0;
        INTERNAL_BUSY = 1'b0;
        TX_EN = 1'b0;
        OP_REQ = 1'b0;
        PROTECT_AREA_FIELD = 4'h0;
        TX_DATA = 8'h00;
        OP_SECTOR = 9'h000;
        PROTOCOL = PR_EXTENDED;
        CMD_LANES = LN_X1;
        void'($urandom(58));
        host_u.wait_cyc(3);
        cmp(DQ_OE_N, `SFPI_OE_FLOAT);
        cmp(STANDBY, 1'b1);
        RST_N = 1'b1;
        host_u.wait_cyc(4);
        for (int i = 0; i < 12; i++) begin
            frame((i % 3 == 0) ? 1 : (i % 3 == 1) ? 2 : 4, (i / 3) % 2, i >= 6);
        end
        // Dual protocol receive, quad protocol send.
        for (int p = 1; p < 3; p++) begin
            PROTOCOL = sfpi_proto_e'(p);
            frame(2 * p, 1'b0, p == 2);
        end
        PROTOCOL = PR_EXTENDED;
        for (int m = 0; m < 5; m++) begin
            pause_case(m);
        end
        for (int n = 0; n < 2; n++) begin
            NVCFG_BIT4 = (n == 0);
            RESTORE_N = 1'b0;
            host_u.wait_cyc(5);
            cmp(IN_RESET, n == 0);
            cmp(DQ_OE_N, `SFPI_OE_FLOAT);
            RESTORE_N = 1'b1;
            NVCFG_BIT4 = 1'b1;
            host_u.wait_cyc(5);
        end
        INTERNAL_BUSY = 1'b1;
        host_u.wait_cyc(5);
        cmp(STANDBY, 1'b0);
        INTERNAL_BUSY = 1'b0;
        $display("restore and busy done");
        for (int i = 0; i < 80; i++) begin
            WP_N = 1'($urandom);
            SR_PROTECT_EN = 1'($urandom);
            PROT_BOTTOM = 1'($urandom);
            PROTECT_AREA_FIELD = (i < 32) ? 4'(i) : 4'($urandom);
            OP_SECTOR = (i % 4 == 0) ? 9'h000 : (i % 4 == 1) ? 9'h1ff : 9'($urandom);
            host_u.wait_cyc(3);
            OP_REQ = 1'b1;
            host_u.wait_cyc(1);
            OP_REQ = 1'b0;
            cmp({OP_GRANT, OP_DENY}, {!exp_deny(WP_N, SR_PROTECT_EN, PROT_BOTTOM, PROTECT_AREA_FIELD, OP_SECTOR),
                                      exp_deny(WP_N, SR_PROTECT_EN, PROT_BOTTOM, PROTECT_AREA_FIELD, OP_SECTOR)});
        end
        $display("protection done");
        results();
    end
endmodule : tb_serial_flash_pin_interface
`default_nettype wire
